// [design/jtsm_pkg.sv]
// Purpose: Shared constants and types of the boundary scan test access port.
// Assumes: Three-bit instruction register, eight boundary cells.
// Notes:   Instruction codes and the identity value are local choices.
package jtsm_pkg;

    localparam int unsigned IR_W = 3;
    localparam int unsigned BSR_LEN = 8;
    localparam int unsigned ID_W = 32;

    // Fixed pattern loaded on instruction capture
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h4;

    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h1;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h2;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

    // Identity value is arbitrary; bit 0 must stay set
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0000A001;

    localparam logic [BSR_LEN-1:0] BSR_RESET_VAL = 8'h00;

    typedef enum logic [3:0] {
        ST_TLR, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
        ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } jtsm_state_t;

    typedef enum logic [1:0] {
        DR_BYP, DR_BSR, DR_ID
    } jtsm_dr_t;

    // Which data register the current instruction puts between TDI and TDO
    function automatic jtsm_dr_t dr_select(input logic [IR_W-1:0] ins);
        jtsm_dr_t sel;
        sel = DR_BYP;
        if ((ins == INS_EXTEST) || (ins == INS_SAMPLE)) begin
            sel = DR_BSR;
        end else if (ins == INS_IDCODE) begin
            sel = DR_ID;
        end
        return sel;
    endfunction

endpackage

// [design/jtsm_sync.sv]
// Purpose: Two-stage synchroniser for levels entering a clock domain.
// Assumes: Each bit is an independent level or is held stable by a handshake.
// Notes:   Output is low during and right after reset.
`timescale 1ns/100ps
`default_nettype none
module jtsm_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule // jtsm_sync
`default_nettype wire

// [design/jtsm_tap.sv]
// Purpose: Boundary scan test access port controller with its registers.
// Assumes: TCK comes from the external tester; core pins live on clk_sys.
// Notes:   Words cross between TCK and clk_sys by toggle handshakes.
`timescale 1ns/100ps
`default_nettype none
module jtsm_tap
    import jtsm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [BSR_LEN-1:0] pin_in,
    output logic [BSR_LEN-1:0] bs_out,
    output logic ext_mode
);

    // ---------------- Reset into the TCK domain
    logic rst_tck_n;

    // Assert at once, release only after two TCK edges
    jtsm_sync #(.W(1)) u_rst_tck (
        .clk(tck),
        .rst_n(rst_n),
        .d(1'b1),
        .q(rst_tck_n)
    );

    // ---------------- System side: pin snapshot towards TCK
    logic [BSR_LEN-1:0] pin_q;
    logic [BSR_LEN-1:0] snap_r;
    logic [BSR_LEN-1:0] snap_nxt;
    logic snap_req_r;
    logic snap_req_nxt;
    logic snap_ack_s;

    jtsm_sync #(.W(BSR_LEN)) u_pin_sync (
        .clk(clk_sys),
        .rst_n(rst_n),
        .d(pin_in),
        .q(pin_q)
    );

    logic snap_ack_r;

    jtsm_sync #(.W(1)) u_snap_ack_sync (
        .clk(clk_sys),
        .rst_n(rst_n),
        .d(snap_ack_r),
        .q(snap_ack_s)
    );

    // ---------------- System side: parallel output from TCK
    logic upd_req_r;
    logic upd_req_s;
    logic upd_ack_r;
    logic upd_ack_nxt;
    logic [BSR_LEN-1:0] bs_out_r;
    logic [BSR_LEN-1:0] bs_out_nxt;
    logic ext_mode_r;
    logic ext_mode_nxt;
    logic [BSR_LEN-1:0] xfer_bs_r;
    logic xfer_ext_r;

    jtsm_sync #(.W(1)) u_upd_req_sync (
        .clk(clk_sys),
        .rst_n(rst_n),
        .d(upd_req_r),
        .q(upd_req_s)
    );

    always_comb begin
        snap_nxt = snap_r;
        snap_req_nxt = snap_req_r;
        upd_ack_nxt = upd_ack_r;
        bs_out_nxt = bs_out_r;
        ext_mode_nxt = ext_mode_r;
        // New snapshot only once the TCK side has taken the last one
        if (snap_ack_s == snap_req_r) begin
            snap_nxt = pin_q;
            snap_req_nxt = ~snap_req_r;
        end
        // Transfer word stays frozen until acknowledged
        if (upd_req_s != upd_ack_r) begin
            bs_out_nxt = xfer_bs_r;
            ext_mode_nxt = xfer_ext_r;
            upd_ack_nxt = upd_req_s;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            snap_r <= BSR_RESET_VAL;
            snap_req_r <= 1'b0;
            upd_ack_r <= 1'b0;
            bs_out_r <= BSR_RESET_VAL;
            ext_mode_r <= 1'b0;
        end else begin
            snap_r <= snap_nxt;
            snap_req_r <= snap_req_nxt;
            upd_ack_r <= upd_ack_nxt;
            bs_out_r <= bs_out_nxt;
            ext_mode_r <= ext_mode_nxt;
        end
    end

    assign bs_out = bs_out_r;
    assign ext_mode = ext_mode_r;

    // ---------------- TCK side, rising edge
    // The pin word is handed over whole under a toggle handshake, so
    // Capture-DR may see pins a few clocks old but never a torn word.
    logic snap_req_s;
    logic upd_ack_s;

    jtsm_sync #(.W(1)) u_snap_req_sync (
        .clk(tck),
        .rst_n(rst_tck_n),
        .d(snap_req_r),
        .q(snap_req_s)
    );

    jtsm_sync #(.W(1)) u_upd_ack_sync (
        .clk(tck),
        .rst_n(rst_tck_n),
        .d(upd_ack_r),
        .q(upd_ack_s)
    );

    jtsm_state_t state_r;
    jtsm_state_t state_nxt;
    logic [IR_W-1:0] ir_sh_r;
    logic [IR_W-1:0] ir_sh_nxt;
    logic [BSR_LEN-1:0] bsr_sh_r;
    logic [BSR_LEN-1:0] bsr_sh_nxt;
    logic [ID_W-1:0] id_sh_r;
    logic [ID_W-1:0] id_sh_nxt;
    logic byp_r;
    logic byp_nxt;
    logic [BSR_LEN-1:0] pins_r;
    logic [BSR_LEN-1:0] pins_nxt;
    logic snap_ack_nxt;
    logic pend_r;
    logic pend_nxt;
    logic upd_req_nxt;
    logic [BSR_LEN-1:0] xfer_bs_nxt;
    logic xfer_ext_nxt;
    logic [IR_W-1:0] ir_r;
    logic [BSR_LEN-1:0] bsr_par_r;
    jtsm_dr_t dr_cur;
    logic load_xfer;

    assign dr_cur = dr_select(ir_r);

    // Next state; TMS high for five edges lands in reset from anywhere
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_TLR: state_nxt = tms ? ST_TLR : ST_IDLE;
            ST_IDLE: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_nxt = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_nxt = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_nxt = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
            default: state_nxt = ST_TLR;
        endcase
    end

    // Shift paths: registers hold in every state but their own
    always_comb begin
        ir_sh_nxt = ir_sh_r;
        bsr_sh_nxt = bsr_sh_r;
        id_sh_nxt = id_sh_r;
        byp_nxt = byp_r;
        case (state_r)
            ST_CAP_IR: ir_sh_nxt = IR_CAPTURE_VAL;
            ST_SH_IR: ir_sh_nxt = {tdi, ir_sh_r[IR_W-1:1]};
            ST_CAP_DR: begin
                if (dr_cur == DR_BSR) begin
                    bsr_sh_nxt = pins_r;
                end
                if (dr_cur == DR_ID) begin
                    id_sh_nxt = ID_VALUE;
                end
                if (dr_cur == DR_BYP) begin
                    byp_nxt = 1'b0;
                end
            end
            ST_SH_DR: begin
                case (dr_cur)
                    DR_BSR: bsr_sh_nxt = {tdi, bsr_sh_r[BSR_LEN-1:1]};
                    DR_ID: id_sh_nxt = {tdi, id_sh_r[ID_W-1:1]};
                    default: byp_nxt = tdi;
                endcase
            end
            default: ;
        endcase
    end

    // Only one word is in flight at a time; a later update simply
    // reloads the latest latch values once the previous word is taken.
    // Pin snapshot and parallel-output handshakes on the TCK side
    assign load_xfer = pend_r && (upd_ack_s == upd_req_r);

    always_comb begin
        pins_nxt = pins_r;
        snap_ack_nxt = snap_ack_r;
        if (snap_req_s != snap_ack_r) begin
            pins_nxt = snap_r;
            snap_ack_nxt = snap_req_s;
        end
        xfer_bs_nxt = xfer_bs_r;
        xfer_ext_nxt = xfer_ext_r;
        upd_req_nxt = upd_req_r;
        if (load_xfer) begin
            xfer_bs_nxt = bsr_par_r;
            xfer_ext_nxt = (ir_r == INS_EXTEST);
            upd_req_nxt = ~upd_req_r;
        end
        // A fresh latch event wins over the load that clears the flag
        pend_nxt = (pend_r && !load_xfer) || (state_r == ST_UPD_DR) || (state_r == ST_UPD_IR) || (state_r == ST_TLR);
    end

    always_ff @(posedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            state_r <= ST_TLR;
            ir_sh_r <= IR_CAPTURE_VAL;
            bsr_sh_r <= BSR_RESET_VAL;
            id_sh_r <= ID_VALUE;
            byp_r <= 1'b0;
            pins_r <= BSR_RESET_VAL;
            snap_ack_r <= 1'b0;
            pend_r <= 1'b0;
            upd_req_r <= 1'b0;
            xfer_bs_r <= BSR_RESET_VAL;
            xfer_ext_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ir_sh_r <= ir_sh_nxt;
            bsr_sh_r <= bsr_sh_nxt;
            id_sh_r <= id_sh_nxt;
            byp_r <= byp_nxt;
            pins_r <= pins_nxt;
            snap_ack_r <= snap_ack_nxt;
            pend_r <= pend_nxt;
            upd_req_r <= upd_req_nxt;
            xfer_bs_r <= xfer_bs_nxt;
            xfer_ext_r <= xfer_ext_nxt;
        end
    end

    // ---------------- TCK side, falling edge
    // Latches change half a period after the state is entered, so
    // the tester's next rising edge sees settled values.
    logic [IR_W-1:0] ir_nxt;
    logic [BSR_LEN-1:0] bsr_par_nxt;
    logic tdo_r;
    logic tdo_nxt;
    logic tdo_oe_r;
    logic tdo_oe_nxt;

    always_comb begin
        ir_nxt = ir_r;
        bsr_par_nxt = bsr_par_r;
        tdo_nxt = 1'b0;
        tdo_oe_nxt = 1'b0;
        case (state_r)
            ST_TLR: ir_nxt = INS_IDCODE;
            ST_UPD_IR: ir_nxt = ir_sh_r;
            ST_UPD_DR: begin
                if (dr_cur == DR_BSR) begin
                    bsr_par_nxt = bsr_sh_r;
                end
            end
            ST_SH_IR: begin
                tdo_nxt = ir_sh_r[0];
                tdo_oe_nxt = 1'b1;
            end
            ST_SH_DR: begin
                case (dr_cur)
                    DR_BSR: tdo_nxt = bsr_sh_r[0];
                    DR_ID: tdo_nxt = id_sh_r[0];
                    default: tdo_nxt = byp_r;
                endcase
                tdo_oe_nxt = 1'b1;
            end
            default: ;
        endcase
    end

    always_ff @(negedge tck or negedge rst_tck_n) begin
        if (!rst_tck_n) begin
            ir_r <= INS_IDCODE;
            bsr_par_r <= BSR_RESET_VAL;
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            ir_r <= ir_nxt;
            bsr_par_r <= bsr_par_nxt;
            tdo_r <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
        end
    end

    assign tdo = tdo_r;
    assign tdo_oe = tdo_oe_r;

endmodule // jtsm_tap
`default_nettype wire

// [sim/jtsm_tap_monitor.sv]
// Purpose: Assertions on the test access port pins.
// Assumes: A shadow state machine follows tms from reset.
// Notes: Sys side checks allow 40 clk_sys for the crossing.
`timescale 1ns/100ps
`default_nettype none
module jtsm_tap_monitor
    import jtsm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [BSR_LEN-1:0] pin_in,
    input wire logic [BSR_LEN-1:0] bs_out,
    input wire logic ext_mode
);
    localparam logic [63:0] NX0 = 64'h1BDDBBA1_46644311;
    localparam logic [63:0] NX1 = 64'h2FEFCC02_87855920;
    jtsm_state_t st_r;
    logic [IR_W-1:0] irs_r;
    logic [IR_W-1:0] ins_r;
    logic evt_r;
    logic [2:0] evs_r;
    logic [7:0] cnt_r;
    logic shift_w;
    assign shift_w = (st_r == ST_SH_DR) || (st_r == ST_SH_IR);
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_TLR;
            irs_r <= '0;
        end else begin
            st_r <= jtsm_state_t'(tms ? NX1[{st_r, 2'b00} +: 4] : NX0[{st_r, 2'b00} +: 4]);
            if (st_r == ST_CAP_IR) begin
                irs_r <= IR_CAPTURE_VAL;
            end else if (st_r == ST_SH_IR) begin
                irs_r <= {tdi, irs_r[IR_W-1:1]};
            end
        end
    end
    // A toggle, since one tck period is shorter than a clk_sys period
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ins_r <= INS_IDCODE;
            evt_r <= 1'b0;
        end else begin
            if (st_r == ST_UPD_IR) begin
                ins_r <= irs_r;
            end else if (st_r == ST_TLR) begin
                ins_r <= INS_IDCODE;
            end
            if ((st_r == ST_UPD_IR) || (st_r == ST_UPD_DR) || (st_r == ST_TLR)) begin
                evt_r <= ~evt_r;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            evs_r <= '0;
            cnt_r <= '0;
        end else begin
            evs_r <= {evs_r[1:0], evt_r};
            if (evs_r[2] != evs_r[1]) begin
                cnt_r <= '0;
            end else if (cnt_r != 8'hFF) begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
    a_oe_shift: assert property (@(posedge tck) disable iff (!rst_n) tdo_oe == shift_w)
        else $error("tdo enable outside shift");
    a_tdo_quiet: assert property (@(posedge tck) disable iff (!rst_n) !tdo_oe |-> !tdo)
        else $error("tdo not low while idle");
    a_cap_first: assert property (@(posedge tck) disable iff (!rst_n)
        ($past(st_r) == ST_CAP_IR) && (st_r == ST_SH_IR) |-> tdo == IR_CAPTURE_VAL[0])
        else $error("capture bit 0 wrong");
    a_cap_last: assert property (@(posedge tck) disable iff (!rst_n)
        ($past(st_r, 3) == ST_CAP_IR) && ($past(st_r, 2) == ST_SH_IR) && ($past(st_r) == ST_SH_IR)
        && (st_r == ST_SH_IR) |-> tdo == IR_CAPTURE_VAL[2])
        else $error("capture bit 2 wrong");
    a_ir_path: assert property (@(posedge tck) disable iff (!rst_n)
        (st_r == ST_SH_IR) [*4] |-> tdo == $past(tdi, 3))
        else $error("instruction path wrong");
    a_bs_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !$stable(bs_out) |-> cnt_r < 8'h28)
        else $error("bs_out moved without update");
    a_mode_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !$stable(ext_mode) |-> cnt_r < 8'h28)
        else $error("ext_mode moved without update");
    a_mode_match: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cnt_r > 8'h28 |-> ext_mode == (ins_r == INS_EXTEST))
        else $error("ext_mode disagrees with instruction");
endmodule // jtsm_tap_monitor
bind jtsm_tap jtsm_tap_monitor u_jtsm_tap_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .bs_out(bs_out), .ext_mode(ext_mode));
`default_nettype wire

// [sim/jtsm_tester.sv]
// Purpose: Model of the external scan tester on the link.
// Assumes: tck stands low between frames.
// Notes: tdi toggles outside scans so a stray sample shows.
`timescale 1ns/100ps
`default_nettype none
module jtsm_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #24;
        tck = 1'b1;
        q = tdo;
        #24;
        tck = 1'b0;
    endtask
    task automatic walk(input logic [15:0] pat, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            tick(pat[i], ~tdi, q);
        end
    endtask
    task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], dout[i]);
        end
    endtask
endmodule // jtsm_tester
`default_nettype wire

// [sim/jtsm_tap_tb.sv]
// Purpose: Self-checking bench for the test access port.
// Assumes: The tester model owns tck, tms and tdi.
// Notes: Idle tck periods after scans let words cross to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module jtsm_tap_tb
    import jtsm_pkg::*;
;
    logic clk_sys;
    logic rst_n;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic [BSR_LEN-1:0] pin_in;
    logic [BSR_LEN-1:0] bs_out;
    logic ext_mode;
    logic [31:0] d;
    logic [31:0] a;
    int miscompares = 0;
    int samples_checked = 0;
    jtsm_tap u_jtsm_tap (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .pin_in(pin_in), .bs_out(bs_out), .ext_mode(ext_mode));
    jtsm_tester u_jtsm_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        if ((miscompares == 0) && (samples_checked > 0)) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic ir_load(input logic [2:0] ins);
        u_jtsm_tester.walk(16'h0003, 4);
        u_jtsm_tester.scan(3, {29'h0, ins}, d);
        check_val("ir capture", {29'h0, IR_CAPTURE_VAL}, {29'h0, d[2:0]});
        u_jtsm_tester.walk(16'h0001, 10);
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic dr_scan(input int n, input logic [31:0] din);
        u_jtsm_tester.walk(16'h0001, 3);
        u_jtsm_tester.scan(n, din, d);
        u_jtsm_tester.walk(16'h0001, 10);
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic sc_bypass();
        ir_load(INS_BYPASS);
        dr_scan(8, 32'hC3);
        check_val("bypass", 32'h86, {24'h0, d[7:0]});
        check_val("mode", 32'h0, {31'h0, ext_mode});
        check_val("bs kept", 32'h69, {24'h0, bs_out});
    endtask
    task automatic sc_idcode();
        dr_scan(32, 32'h0);
        check_val("idcode", ID_VALUE, d);
        check_val("mode", 32'h0, {31'h0, ext_mode});
        check_val("bs out", 32'h0, {24'h0, bs_out});
    endtask
    task automatic sc_sample();
        @(posedge clk_sys);
        pin_in <= 8'hA5;
        u_jtsm_tester.walk(16'h0000, 20);
        ir_load(INS_SAMPLE);
        dr_scan(8, 32'h3C);
        check_val("pins", 32'hA5, {24'h0, d[7:0]});
        check_val("bs out", 32'h3C, {24'h0, bs_out});
    endtask
    task automatic sc_pause_dr();
        @(posedge clk_sys);
        pin_in <= 8'h5A;
        u_jtsm_tester.walk(16'h0000, 20);
        u_jtsm_tester.walk(16'h0001, 3);
        u_jtsm_tester.scan(4, 32'h9, a);
        u_jtsm_tester.walk(16'h0004, 4);
        repeat (6) @(posedge clk_sys);
        check_val("bs held", 32'h3C, {24'h0, bs_out});
        u_jtsm_tester.scan(4, 32'h6, d);
        u_jtsm_tester.walk(16'h0006, 12);
        repeat (6) @(posedge clk_sys);
        check_val("paused scan", 32'h5A, {24'h0, d[3:0], a[3:0]});
        check_val("bs out", 32'h69, {24'h0, bs_out});
    endtask
    task automatic sc_extest();
        u_jtsm_tester.walk(16'h0003, 4);
        u_jtsm_tester.scan(2, 32'h0, a);
        u_jtsm_tester.walk(16'h0002, 3);
        u_jtsm_tester.scan(1, 32'h0, d);
        u_jtsm_tester.walk(16'h0006, 12);
        repeat (6) @(posedge clk_sys);
        check_val("ir paused", 32'h4, {29'h0, d[0], a[1:0]});
        check_val("mode", 32'h1, {31'h0, ext_mode});
        check_val("bs kept", 32'h69, {24'h0, bs_out});
    endtask
    task automatic sc_escape();
        u_jtsm_tester.walk(16'h0003, 4);
        u_jtsm_tester.walk(16'h0000, 4);
        u_jtsm_tester.walk(16'h001F, 5);
        u_jtsm_tester.walk(16'h0000, 10);
        dr_scan(32, 32'h0);
        check_val("idcode", ID_VALUE, d);
        check_val("mode", 32'h0, {31'h0, ext_mode});
        check_val("bs kept", 32'h69, {24'h0, bs_out});
    endtask
    initial begin
        rst_n = 1'b0;
        pin_in = '0;
        u_jtsm_tester.walk(16'h0003, 3);
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        u_jtsm_tester.walk(16'h001F, 5);
        u_jtsm_tester.walk(16'h0000, 2);
        sc_idcode();
        sc_sample();
        sc_pause_dr();
        sc_extest();
        sc_escape();
        sc_bypass();
        end_sim();
    end
    // Whole run is near 20 us; a hang is cut well past that
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
endmodule // jtsm_tap_tb
`default_nettype wire
